// ---- core/vrscp_link.sv ----
// Serial link shifter on the serial clock
`timescale 1ns/1ps
`include "vrscp_regs.svh"
module vrscp_link (
    input  wire logic                   i_sclk,
    input  wire logic                   i_ss_n,
    input  wire logic                   i_mosi,
    input  wire logic [1:0]             i_status,
    output logic                        o_miso,
    output logic                        o_miso_oe,
    output logic [`VRSCP_FRAME_BITS-1:0] o_frame,
    output logic [`VRSCP_CNT_W-1:0]     o_count
);

    logic [1:0] status_s;
    logic [`VRSCP_CNT_W-1:0] count_next;
    logic       out_bit;
    logic       started_reg;

    // Interrupt flags brought onto the serial clock
    vrscp_sync #(.W(2)) u_status_sync (
        .i_clk (i_sclk),
        .i_d   (i_status),
        .o_q   (status_s)
    );

    assign count_next = !started_reg ? `VRSCP_CNT_FIRST :
                        (o_count == `VRSCP_CNT_MAX) ? o_count : o_count + 5'h01;
    assign out_bit    = (o_count == `VRSCP_OUT_FULL) ? status_s[1] :
                        (o_count == `VRSCP_OUT_END)  ? status_s[0] : 1'b0;
    assign o_miso_oe  = ~i_ss_n;

    // Frame marker, cleared while slave select is high
    always_ff @(posedge i_sclk or posedge i_ss_n) begin
        if (i_ss_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Sample input on rising edge, msb first; count restarts at the first edge of a frame
    // Count and frame stand after select rises, so the decoder reads them once settled
    // A select pulse with no clock edges leaves the previous count standing
    always_ff @(posedge i_sclk) begin
        if (!i_ss_n) begin
            o_frame <= {o_frame[`VRSCP_FRAME_BITS-2:0], i_mosi};
            o_count <= count_next;
        end
    end

    // Output bit changes on falling edge while status shifts out
    always_ff @(negedge i_sclk or posedge i_ss_n) begin
        if (i_ss_n) begin
            o_miso <= 1'b0;
        end else begin
            o_miso <= out_bit;
        end
    end

endmodule

// ---- core/vrscp_pkg.sv ----
// Types of the voice recorder serial command port
package vrscp_pkg;

    // Operation state, one-hot
    typedef enum logic [3:0] {
        VRSCP_IDLE    = 4'h1,
        VRSCP_PLAY    = 4'h2,
        VRSCP_CAPTURE = 4'h4,
        VRSCP_SKIP    = 4'h8
    } vrscp_state_t;

endpackage

// ---- core/vrscp_port.sv ----
// Serial command port: frame decode, operation control, interrupt status
//
// Contract
// - Input bit sampled on rising serial clock; host changes data on falling edge.
// - Output bit changes on falling serial clock edge.
// - Falling slave select starts a new frame.
// - Frame is eight control bits plus sixteen data bits, 24 in all.
// - Message end or array full ending an operation raises interrupt.
// - Pending interrupt clears when the next complete frame ends.
// - Status shifts out while control and data shift in.
// - Received instruction acts only when slave select rises.
// - Playback or capture runs while run bit is one, stops when cleared.
// - Skip runs 1600 times faster, stops at marker, pointer at next message.
// - Control 01X0 0010 loads config zero, 01X0 0100 loads config one.
// - 1110 0000 plays from given address, 1111 0000 from present address.
// - 1010 0000 captures at given address, 1011 0000 from present address.
// - 1111 1000 skips one message, or enters array full at array end.
// - 0111 0000 halts; 0101 0000 halts then enters standby.
// - Status read returns array full and message end bits.
// - Wake command 0110 0000 then wait 25 ms before operations.
// - Wake, wait, load both configs, play at address; interrupt at marker.
// - Capture runs to array full or halt, then interrupts and stops.
// - Config zero takes effect only with config one, at that frame's end.
// - First two bytes are data or address, third byte is control.
// - Address ignore bit one keeps internal pointer, zero loads given address.
// - Master power bit one wakes, zero sleeps; play bit selects play or capture.
// - Load bits one write config zero or one; zero loads nothing.
`timescale 1ns/1ps
`include "vrscp_regs.svh"
module vrscp_port #(
    parameter int WAKE_CYCLES = `VRSCP_WAKE_US * `VRSCP_CLK_MHZ,
    parameter int SKIP_RATIO  = `VRSCP_SKIP_RATIO
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    input  wire logic                 i_ce,
    input  wire logic                 i_sclk,
    input  wire logic                 i_ss_n,
    input  wire logic                 i_mosi,
    output logic                      o_miso,
    output logic                      o_miso_oe,
    input  wire logic                 i_sample_tick,
    input  wire logic                 i_message_end,
    output logic                      o_powered,
    output logic                      o_ready,
    output vrscp_pkg::vrscp_state_t   o_state,
    output logic [15:0]               o_pointer,
    output logic [15:0]               o_config_reg_zero,
    output logic [15:0]               o_config_reg_one,
    output logic                      o_array_full_flag,
    output logic                      o_message_end_flag
);
    import vrscp_pkg::*;

    localparam int WW = $clog2(WAKE_CYCLES + 1);
    localparam int RW = $clog2(SKIP_RATIO + 1);

    // ****************************************************************
    // Link and crossing
    // ****************************************************************
    logic [`VRSCP_FRAME_BITS-1:0] frame;
    logic [`VRSCP_CNT_W-1:0]      count;
    logic                         ss_s;
    logic                         ss_d_reg;

    vrscp_link u_link (
        .i_sclk    (i_sclk),
        .i_ss_n    (i_ss_n),
        .i_mosi    (i_mosi),
        .i_status  ({o_array_full_flag, o_message_end_flag}),
        .o_miso    (o_miso),
        .o_miso_oe (o_miso_oe),
        .o_frame   (frame),
        .o_count   (count)
    );

    vrscp_sync #(.W(1)) u_ss_sync (
        .i_clk (i_clk),
        .i_d   (i_ss_n),
        .o_q   (ss_s)
    );

    // Edge history of slave select
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ss_d_reg <= 1'b1;
        end else if (i_ce) begin
            ss_d_reg <= ss_s;
        end
    end

    // ****************************************************************
    // Frame decode
    // ****************************************************************
    wire        ss_rise   = i_ce & ss_s & ~ss_d_reg;
    wire        frame_ok  = ss_rise & (count == `VRSCP_CNT_FULL);
    wire [15:0] data      = frame[`VRSCP_DATA_HI:`VRSCP_DATA_LO];
    wire [7:0]  ctl       = frame[`VRSCP_CTRL_HI:`VRSCP_CTRL_LO];
    wire        ctl_run   = ctl[`VRSCP_BIT_RUN];
    wire        ctl_play  = ctl[`VRSCP_BIT_PLAY];
    wire        ctl_pu    = ctl[`VRSCP_BIT_POWER];
    wire        ctl_ign   = ctl[`VRSCP_BIT_IGNORE];
    wire        ctl_skip  = ctl[`VRSCP_BIT_SKIP];
    wire        ctl_lc1   = ctl[`VRSCP_BIT_LOAD1];
    wire        ctl_lc0   = ctl[`VRSCP_BIT_LOAD0];
    wire        is_load   = ctl_lc0 | ctl_lc1;
    wire        op_frame  = frame_ok & ~is_load;
    wire        do_sleep  = op_frame & ~ctl_pu;
    wire        do_wake   = op_frame & ctl_pu & ~o_powered;
    wire        do_start  = op_frame & ctl_pu & ctl_run & o_ready;
    wire        do_halt   = op_frame & ~ctl_run;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [15:0] config_reg_zero_shadow_reg;
    wire  [15:0] config_reg_zero_next = ctl_lc0 ? data : config_reg_zero_shadow_reg;

    // Config zero waits in a shadow until config one is written
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            config_reg_zero_shadow_reg <= `VRSCP_CFG_RESET;
            o_config_reg_zero          <= `VRSCP_CFG_RESET;
            o_config_reg_one          <= `VRSCP_CFG_RESET;
        end else if (frame_ok) begin
            if (ctl_lc0) begin
                config_reg_zero_shadow_reg <= data;
            end
            if (ctl_lc1) begin
                o_config_reg_one <= data;
                o_config_reg_zero <= config_reg_zero_next;
            end
        end
    end

    // ****************************************************************
    // Power and wake delay
    // ****************************************************************
    logic [WW-1:0] wake_cnt_reg;

    // Ready only after the wake delay has run out
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_powered    <= 1'b0;
            o_ready      <= 1'b0;
            wake_cnt_reg <= '0;
        end else if (i_ce) begin
            if (do_sleep) begin
                o_powered <= 1'b0;
                o_ready   <= 1'b0;
            end else if (do_wake) begin
                o_powered    <= 1'b1;
                wake_cnt_reg <= WW'(WAKE_CYCLES - 1);
            end else if (o_powered && !o_ready) begin
                if (wake_cnt_reg == '0) begin
                    o_ready <= 1'b1;
                end else begin
                    wake_cnt_reg <= wake_cnt_reg - WW'(1);
                end
            end
        end
    end

    // ****************************************************************
    // Operation engine
    // ****************************************************************
    vrscp_state_t  state_reg;
    vrscp_state_t  state_next;
    logic [RW-1:0] row_cnt_reg;
    wire           busy     = (state_reg != VRSCP_IDLE);
    wire           row_due  = (row_cnt_reg == RW'(SKIP_RATIO - 1));
    // Skip steps a row every tick, play and capture every SKIP_RATIO ticks
    wire           advance  = i_ce & busy & i_sample_tick & ((state_reg == VRSCP_SKIP) | row_due);
    wire           at_last  = (o_pointer == `VRSCP_PTR_LAST);
    wire           hit_full = advance & at_last;
    wire           hit_end  = i_ce & i_message_end & ((state_reg == VRSCP_PLAY) | (state_reg == VRSCP_SKIP));
    wire           cap_halt = (state_reg == VRSCP_CAPTURE) & (do_halt | do_sleep);
    wire           full_set = hit_full;
    wire           end_set  = (hit_end & ~hit_full) | cap_halt;

    assign o_state = state_reg;

    // Next operation state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            VRSCP_IDLE: begin
                state_next = VRSCP_IDLE;
            end
            VRSCP_PLAY, VRSCP_CAPTURE, VRSCP_SKIP: begin
                if (hit_full || hit_end) begin
                    state_next = VRSCP_IDLE;
                end
            end
            default: begin
                state_next = VRSCP_IDLE;
            end
        endcase
        if (do_halt || do_sleep) begin
            state_next = VRSCP_IDLE;
        end else if (do_start) begin
            if (ctl_play && ctl_skip) begin
                state_next = VRSCP_SKIP;
            end else if (ctl_play) begin
                state_next = VRSCP_PLAY;
            end else begin
                state_next = VRSCP_CAPTURE;
            end
        end
    end

    // Operation state register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= VRSCP_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Row pacing counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            row_cnt_reg <= '0;
        end else if (i_ce) begin
            if (do_start || !busy) begin
                row_cnt_reg <= '0;
            end else if (i_sample_tick) begin
                row_cnt_reg <= row_due ? '0 : row_cnt_reg + RW'(1);
            end
        end
    end

    // Internal address pointer
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pointer <= `VRSCP_PTR_RESET;
        end else if (i_ce) begin
            if (do_start && !ctl_ign) begin
                o_pointer <= data;
            end else if (hit_end && state_reg == VRSCP_SKIP) begin
                o_pointer <= o_pointer + `VRSCP_PTR_STEP;
            end else if (advance && !at_last) begin
                o_pointer <= o_pointer + `VRSCP_PTR_STEP;
            end
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Set wins over the clear of a frame ending in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_array_full_flag  <= 1'b0;
            o_message_end_flag <= 1'b0;
        end else if (i_ce) begin
            o_array_full_flag  <= full_set | (o_array_full_flag & ~frame_ok);
            o_message_end_flag <= end_set | (o_message_end_flag & ~frame_ok);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_frame_clears: assert property (frame_ok && !full_set && !end_set |=>
        !o_array_full_flag && !o_message_end_flag)
        else $error("flags not cleared by complete frame");
    a_full_sets: assert property (full_set |=> o_array_full_flag && o_state == VRSCP_IDLE)
        else $error("array full did not flag and stop");
    a_short_frame: assert property (ss_rise && count != `VRSCP_CNT_FULL |=>
        $stable(o_config_reg_one) && $stable(config_reg_zero_shadow_reg) && $stable(o_powered))
        else $error("partial frame changed state");
    a_config_reg_zero_apply: assert property (frame_ok && ctl_lc1 && !ctl_lc0 |=> o_config_reg_zero == $past(config_reg_zero_shadow_reg))
        else $error("config zero not applied with config one");
    a_config_reg_zero_waits: assert property ($changed(o_config_reg_zero) |-> $past(frame_ok) && $past(ctl_lc1))
        else $error("config zero changed without config one");
    a_halt_sleep: assert property (do_sleep |=> !o_powered && !o_ready && o_state == VRSCP_IDLE)
        else $error("halt and sleep failed");
    a_run_clear: assert property (do_halt |=> o_state == VRSCP_IDLE)
        else $error("run bit clear did not stop");
    a_capture_halt: assert property (cap_halt |=> o_message_end_flag)
        else $error("capture halt without interrupt");
    a_skip_next: assert property (hit_end && !hit_full && state_reg == VRSCP_SKIP && !do_start
        |=> o_pointer == $past(o_pointer) + `VRSCP_PTR_STEP && o_state == VRSCP_IDLE)
        else $error("skip did not stop at next message");
    a_wake_gap: assert property (do_wake |=> !o_ready [*2])
        else $error("ready too soon after wake");
    a_wake_power: assert property (do_wake |=> o_powered)
        else $error("wake did not power up");
    a_early_refused: assert property (op_frame && ctl_run && ctl_pu && !o_ready && !busy
        |=> o_state == VRSCP_IDLE)
        else $error("operation started inside wake delay");

    // Start decode and pointer load
    a_play_start: assert property (do_start && ctl_play && !ctl_skip
        |=> o_state == VRSCP_PLAY)
        else $error("play did not start");
    a_capture_start: assert property (do_start && !ctl_play
        |=> o_state == VRSCP_CAPTURE)
        else $error("capture did not start");
    a_skip_start: assert property (do_start && ctl_play && ctl_skip
        |=> o_state == VRSCP_SKIP)
        else $error("skip did not start");
    a_addr_load: assert property (do_start && !ctl_ign
        |=> o_pointer == $past(data))
        else $error("given address not loaded");
    a_addr_keep: assert property (do_start && ctl_ign && !advance && !hit_end
        |=> o_pointer == $past(o_pointer))
        else $error("pointer moved although address ignored");

    // Configuration loads
    a_load_config_reg_one: assert property (frame_ok && ctl_lc1
        |=> o_config_reg_one == $past(data))
        else $error("config one not loaded");
    a_load_config_reg_zero: assert property (frame_ok && ctl_lc0
        |=> config_reg_zero_shadow_reg == $past(data))
        else $error("config zero not captured");
    a_load_no_run: assert property (frame_ok && is_load
        |=> $stable(o_powered) && o_state == $past(state_next))
        else $error("load frame changed power");

    // Interrupt flags
    a_marker_end: assert property (hit_end && !hit_full && !do_start
        |=> o_message_end_flag && o_state == VRSCP_IDLE)
        else $error("message end did not flag and stop");
    a_flag_hold: assert property (!frame_ok
        |=> (o_array_full_flag || !$past(o_array_full_flag)) && (o_message_end_flag || !$past(o_message_end_flag)))
        else $error("flag dropped without a frame");

    c_play: cover property (do_start && ctl_play && !ctl_skip ##[1:40] o_message_end_flag);
    c_refused: cover property (op_frame && ctl_run && o_powered && !o_ready);
    c_capture: cover property (o_state == VRSCP_CAPTURE ##[1:50] cap_halt);
    c_skip: cover property (o_state == VRSCP_SKIP ##1 o_state == VRSCP_IDLE);
    c_cfg: cover property (frame_ok && ctl_lc1);

endmodule

// ---- core/vrscp_regs.svh ----
// Constants of the voice recorder serial command port
`ifndef VRSCP_REGS_SVH
`define VRSCP_REGS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define VRSCP_FRAME_BITS    24
`define VRSCP_CNT_W         5
`define VRSCP_CNT_FULL      5'h18
`define VRSCP_CNT_MAX       5'h1F
`define VRSCP_CNT_FIRST     5'h01
`define VRSCP_DATA_HI       23
`define VRSCP_DATA_LO       8
`define VRSCP_CTRL_HI       7
`define VRSCP_CTRL_LO       0

// ****************************************************************
// Control byte bit positions
// ****************************************************************
`define VRSCP_BIT_RUN       7
`define VRSCP_BIT_PLAY      6
`define VRSCP_BIT_POWER     5
`define VRSCP_BIT_IGNORE    4
`define VRSCP_BIT_SKIP      3
`define VRSCP_BIT_LOAD1     2
`define VRSCP_BIT_LOAD0     1

// ****************************************************************
// Status bits shifted out, by output bit index
// ****************************************************************
// Index 2 first, so the flags have passed both synchroniser stages
`define VRSCP_OUT_FULL      5'h02
`define VRSCP_OUT_END       5'h03

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define VRSCP_CFG_RESET     16'h0000
`define VRSCP_PTR_RESET     16'h0000
`define VRSCP_PTR_LAST      16'hFFFF
`define VRSCP_PTR_STEP      16'h0001
`define VRSCP_CLK_MHZ       40
`define VRSCP_WAKE_US       25000
`define VRSCP_SKIP_RATIO    1600

`endif

// ---- core/vrscp_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module vrscp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        o_q      <= meta_reg;
    end

endmodule

// ---- verif/tb_top.sv ----
// Self-checking testbench of the serial command port
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); fails++; end end
module tb_top;
    import vrscp_pkg::*;
    localparam int WAKE = 200;
    localparam int RATIO = 4;
    logic          i_clk, i_reset, i_ce, i_sample_tick, i_message_end;
    logic          sclk, ss_n, mosi, miso, miso_oe;
    logic          powered, ready, full_flag, end_flag;
    vrscp_state_t  state;
    logic [15:0]   pointer, config_reg_zero, config_reg_one, a, d0, d1;
    logic [1:0]    st;
    int            fails, comparisons, i;
    int            seed = 32'he05730cd;

    // Clock at 40 MHz
    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;

    vrscp_port #(.WAKE_CYCLES(WAKE), .SKIP_RATIO(RATIO)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sclk(sclk), .i_ss_n(ss_n),
        .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_sample_tick(i_sample_tick),
        .i_message_end(i_message_end), .o_powered(powered), .o_ready(ready), .o_state(state),
        .o_pointer(pointer), .o_config_reg_zero(config_reg_zero), .o_config_reg_one(config_reg_one), .o_array_full_flag(full_flag),
        .o_message_end_flag(end_flag));

    vrscp_host host (.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Control byte for a configuration load, with the ignored bit set as asked
    function automatic logic [7:0] load_ctrl(input logic one, input logic x);
        return {2'b01, x, 2'b00, one, ~one, 1'b0};
    endfunction

    // Pointer after a number of whole steps
    function automatic logic [15:0] ptr_after(input logic [15:0] p, input int steps);
        return p + 16'(steps);
    endfunction

    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic frame(input logic [15:0] d, input logic [7:0] c, input int n);
        host.send_frame({d, c}, n, st);
        repeat (8) @(posedge i_clk);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            i_sample_tick = 1'b1;
            @(posedge i_clk);
            #1 i_sample_tick = 1'b0;
            @(posedge i_clk);
            #1;
        end
    endtask

    task automatic marker;
        i_message_end = 1'b1;
        @(posedge i_clk);
        #1 i_message_end = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        complete_run;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_sample_tick = 1'b0;
        i_message_end = 1'b0;
        repeat (20) @(posedge i_clk);
        #1 i_reset = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        `CHECK("reset state", VRSCP_IDLE, state)
        `CHECK("reset flags", 4'h0, {powered, ready, full_flag, end_flag})
        `CHECK("reset miso", 2'b00, {miso, miso_oe})
        $display("test reset done");

        // Wake, an operation inside the wake delay is refused, then ready
        frame(16'h0000, 8'h60, 24);
        `CHECK("powered", 2'b10, {powered, ready})
        frame(16'h1234, 8'hE0, 24);
        `CHECK("early start", {VRSCP_IDLE, 1'b0}, {state, ready})
        repeat (WAKE) @(posedge i_clk);
        #1;
        `CHECK("ready", 1'b1, ready)
        $display("test wake done");

        // Random configuration loads, config zero held back until config one
        for (i = 0; i < 3; i++) begin
            d0 = 16'($random(seed));
            d1 = 16'($random(seed));
            a = config_reg_zero;
            frame(d0, load_ctrl(1'b0, i[0]), 24);
            `CHECK("config_reg_zero held", a, config_reg_zero)
            frame(d1, load_ctrl(1'b1, 1'b0), 23);
            `CHECK("partial frame", a, config_reg_zero)
            frame(d1, load_ctrl(1'b1, ~i[0]), 24);
            `CHECK("config_reg_zero applied", d0, config_reg_zero)
            `CHECK("config_reg_one", d1, config_reg_one)
            `CHECK("load no run", VRSCP_IDLE, state)
        end
        $display("test config done");

        // Play at address, clock enable freeze, marker ends play
        a = 16'($random(seed)) & 16'h7FFF;
        frame(a, 8'hE0, 24);
        `CHECK("play state", VRSCP_PLAY, state)
        `CHECK("play addr", a, pointer)
        i_ce = 1'b0;
        ticks(RATIO);
        i_ce = 1'b1;
        `CHECK("frozen", a, pointer)
        ticks(RATIO);
        `CHECK("play step", ptr_after(a, 1), pointer)
        marker;
        `CHECK("play end", {VRSCP_IDLE, 2'b01}, {state, full_flag, end_flag})
        frame(16'hFFFF, 8'h70, 24);
        `CHECK("status end", 2'b10, st)
        `CHECK("flag clear", 2'b00, {full_flag, end_flag})
        $display("test play done");

        // Message skip from present pointer runs per tick and stops past marker
        frame(16'h0000, 8'hF8, 24);
        `CHECK("skip state", VRSCP_SKIP, state)
        ticks(3);
        `CHECK("skip rate", ptr_after(a, 4), pointer)
        marker;
        `CHECK("skip ptr", ptr_after(a, 5), pointer)
        `CHECK("skip end", {VRSCP_IDLE, 2'b01}, {state, full_flag, end_flag})
        $display("test skip done");

        // Capture at last address fills the array; status frame reads and clears
        frame(16'hFFFF, 8'hA0, 24);
        `CHECK("cap state", VRSCP_CAPTURE, state)
        `CHECK("end cleared", 1'b0, end_flag)
        ticks(RATIO);
        `CHECK("full", {VRSCP_IDLE, 2'b10, 16'hFFFF}, {state, full_flag, end_flag, pointer})
        frame(16'h0000, 8'h70, 24);
        `CHECK("status full", 2'b01, st)
        $display("test capture full done");

        // Play and capture from present address, capture halted by a frame
        frame(16'h1111, 8'hF0, 24);
        `CHECK("play here", {VRSCP_PLAY, 16'hFFFF}, {state, pointer})
        frame(16'h2222, 8'hB0, 24);
        `CHECK("cap here", {VRSCP_CAPTURE, 16'hFFFF}, {state, pointer})
        frame(16'h0000, 8'h70, 24);
        `CHECK("halt", {VRSCP_IDLE, 1'b1}, {state, end_flag})
        $display("test halt done");

        // Halt and sleep, then refused start
        frame(16'h0000, 8'h50, 24);
        `CHECK("sleep", 2'b00, {powered, ready})
        frame(16'h0040, 8'hE0, 24);
        `CHECK("asleep play", VRSCP_IDLE, state)
        $display("test sleep done");
        complete_run;
    end
endmodule

// ---- verif/vrscp_host.sv ----
// Host side model: serial link master driving frames into the command port
`timescale 1ns/1ps
module vrscp_host (
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe
);
    // Link idles with clock low and select high; one select pulse clears the frame marker
    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b0;
        o_mosi = 1'b1;
        #1 o_ss_n = 1'b1;
    end

    // Shift one frame of nbits, capture the two status bits on rising edges
    task automatic send_frame(input logic [23:0] frame, input int nbits, output logic [1:0] status);
        int k;
        status = 2'b00;
        #5;
        o_ss_n = 1'b0;
        for (k = 0; k < nbits; k++) begin
            o_mosi = frame[23-k];
            #32 o_sclk = 1'b1;
            if (k == 2 && i_miso_oe === 1'b1) begin
                status[0] = i_miso;
            end
            if (k == 3 && i_miso_oe === 1'b1) begin
                status[1] = i_miso;
            end
            #32 o_sclk = 1'b0;
        end
        #32 o_ss_n = 1'b1;
        o_mosi = ~o_mosi;                        // Released line shows no stale value
    endtask
endmodule
